// ==== qfp_fetch_pipe.v ====
`include "qfp_consts.vh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Oscillator clock divided by four into four non-overlapping phases per cycle.
// - Program counter increments in phase one of every instruction cycle.
// - Next instruction word read and captured in phase four of fetch.
// - Fetched word enters instruction register at phase one, executes phases two-four.
// - Operand read in phase two, destination written in phase four.
// - Fetch overlaps execution, one instruction completes per cycle.
// - Instructions that change the program counter take two cycles.
// - On a branch the prefetched word is flushed; the word after the target is fetched, then executed.
// - In RC mode the clock output pin toggles at a quarter oscillator rate.
// - Master clear input is an active-low reset held while low.
// - A two-bit field selects one of four oscillator modes.
module qfp_fetch_pipe #(
    parameter PC_W = `QFP_PC_W,
    parameter INSTR_W = `QFP_INSTR_W,
    parameter DATA_W = `QFP_DATA_W,
    parameter DADDR_W = `QFP_DADDR_W
) (
    input wire clock,
    input wire rst_b,
    input wire master_clear_n,
    input wire [1:0] osc_mode_select,
    input wire [INSTR_W-1:0] progData,
    input wire execBranch,
    input wire [PC_W-1:0] branchTarget,
    input wire [DADDR_W-1:0] execDataAddr,
    input wire execWriteEn,
    input wire [DATA_W-1:0] execResult,
    output reg [PC_W-1:0] progAddr_q,
    output reg progRead_q,
    output reg [INSTR_W-1:0] instrReg_q,
    output reg instrValid_q,
    output reg [DADDR_W-1:0] dataAddr_q,
    output reg dataRead_q,
    output reg dataWrite_q,
    output reg [DATA_W-1:0] dataWdata_q,
    output reg phaseOne_q,
    output reg phaseTwo_q,
    output reg phaseThree_q,
    output reg phaseFour_q,
    output reg instr_rate_clock_out_q,
    output reg instr_rate_clock_oe_q
);

    // ----------------------------------------
    // Master clear synchroniser
    // ----------------------------------------
    reg [`QFP_SYNC_LEN-1:0] mclrSync_q;
    reg coreRun_q;
    wire coreRst_b;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mclrSync_q <= {`QFP_SYNC_LEN{1'b0}};
        end else begin
            mclrSync_q <= {mclrSync_q[`QFP_SYNC_LEN-2:0], master_clear_n};
        end
    end

    // Level counts once second and third stages agree
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            coreRun_q <= 1'b0;
        end else if (mclrSync_q[1] == mclrSync_q[2]) begin
            coreRun_q <= mclrSync_q[2];
        end
    end

    // Synchronous hold, also the phase generator's async reset: deassertion is already clean
    assign coreRst_b = coreRun_q;

    // ----------------------------------------
    // Phase generator
    // ----------------------------------------
    wire [3:0] phase;

    // Held at phase one while the core is held, so every run opens on phase one
    qfp_phase_gen u_phase (
        .clock(clock),
        .rst_b(coreRst_b),
        .phase_q(phase)
    );

    // ----------------------------------------
    // Phase decode
    // ----------------------------------------
    function phaseIs;
        input [3:0] ph;
        input [3:0] code;
        begin
            phaseIs = (ph == code);
        end
    endfunction

    // Phase forced idle while the core is held so no strobe leaks out
    wire [3:0] curPhase = coreRst_b ? phase : 4'h0;
    wire inPh1 = phaseIs(curPhase, `QFP_PH_ONE);
    wire inPh2 = phaseIs(curPhase, `QFP_PH_TWO);
    wire inPh3 = phaseIs(curPhase, `QFP_PH_THREE);
    wire inPh4 = phaseIs(curPhase, `QFP_PH_FOUR);

    // ----------------------------------------
    // Fetch / execute pipeline
    // ----------------------------------------
    reg [INSTR_W-1:0] fetchBuf_q;
    reg fetchValid_q;
    reg flush_q;
    // Branch only counts for a live instruction; a flushed slot cannot jump
    wire takeBranch = inPh4 && instrValid_q && execBranch;

    // Program counter and fetch strobe
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            progAddr_q <= `QFP_PC_RESET;
            progRead_q <= 1'b0;
        end else if (!coreRst_b) begin
            progAddr_q <= `QFP_PC_RESET;
            progRead_q <= 1'b0;
        end else begin
            progRead_q <= inPh4;
            if (takeBranch) begin
                // Target replaces the increment; next phase one steps past it
                progAddr_q <= branchTarget;
            end else if (inPh1) begin
                progAddr_q <= progAddr_q + 1'b1;
            end
        end
    end

    // Prefetch buffer and instruction register
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            fetchBuf_q <= `QFP_NOP;
            fetchValid_q <= 1'b0;
            instrReg_q <= `QFP_NOP;
            instrValid_q <= 1'b0;
            flush_q <= 1'b0;
        end else if (!coreRst_b) begin
            fetchValid_q <= 1'b0;
            instrValid_q <= 1'b0;
            flush_q <= 1'b0;
        end else begin
            if (inPh1) begin
                // Fetched word moves to execute while next fetch starts
                instrReg_q <= fetchBuf_q;
                instrValid_q <= fetchValid_q && !flush_q;
                flush_q <= 1'b0;
            end
            if (inPh4) begin
                fetchBuf_q <= progData;
                fetchValid_q <= 1'b1;
                if (takeBranch) begin
                    flush_q <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Data memory strobes
    // ----------------------------------------
    reg [DADDR_W-1:0] opAddr_q;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            opAddr_q <= {DADDR_W{1'b0}};
            dataAddr_q <= {DADDR_W{1'b0}};
            dataRead_q <= 1'b0;
            dataWrite_q <= 1'b0;
            dataWdata_q <= {DATA_W{1'b0}};
        end else if (!coreRst_b) begin
            dataRead_q <= 1'b0;
            dataWrite_q <= 1'b0;
        end else begin
            dataRead_q <= inPh2 && instrValid_q;
            dataWrite_q <= inPh4 && instrValid_q && execWriteEn;
            if (inPh2) begin
                dataAddr_q <= execDataAddr;
                opAddr_q <= execDataAddr;
            end
            if (inPh4) begin
                // Address re-driven so the write lands where the read came from
                dataAddr_q <= opAddr_q;
                dataWdata_q <= execResult;
            end
        end
    end

    // ----------------------------------------
    // Phase indicators
    // ----------------------------------------
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phaseOne_q <= 1'b0;
            phaseTwo_q <= 1'b0;
            phaseThree_q <= 1'b0;
            phaseFour_q <= 1'b0;
        end else begin
            phaseOne_q <= inPh1;
            phaseTwo_q <= inPh2;
            phaseThree_q <= inPh3;
            phaseFour_q <= inPh4;
        end
    end

    // ----------------------------------------
    // Instruction-rate clock pin
    // ----------------------------------------
    wire rcMode = (osc_mode_select == `QFP_MODE_RC);

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            instr_rate_clock_out_q <= 1'b0;
            instr_rate_clock_oe_q <= 1'b0;
        end else begin
            // High in phases three and four: 50% duty at a quarter rate
            instr_rate_clock_out_q <= rcMode && (inPh3 || inPh4);
            instr_rate_clock_oe_q <= rcMode;
        end
    end

endmodule

`default_nettype wire

// ==== qfp_consts.vh ====
`ifndef QFP_CONSTS_VH
`define QFP_CONSTS_VH

// ----------------------------------------
// Phase codes, one-hot
// ----------------------------------------
`define QFP_PH_ONE 4'h1
`define QFP_PH_TWO 4'h2
`define QFP_PH_THREE 4'h4
`define QFP_PH_FOUR 4'h8

// ----------------------------------------
// Oscillator modes
// ----------------------------------------
`define QFP_MODE_LP 2'h0
`define QFP_MODE_XT 2'h1
`define QFP_MODE_HS 2'h2
`define QFP_MODE_RC 2'h3

// ----------------------------------------
// Reset values and widths
// ----------------------------------------
`define QFP_PC_W 11
`define QFP_INSTR_W 12
`define QFP_DATA_W 8
`define QFP_DADDR_W 7
`define QFP_PC_RESET 11'h000
`define QFP_NOP 12'h000
`define QFP_SYNC_LEN 3

`endif

// ==== qfp_phase_gen.v ====
`include "qfp_consts.vh"
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Quadrature phase generator
// ----------------------------------------
module qfp_phase_gen (
    input wire clock,
    input wire rst_b,
    output reg [3:0] phase_q
);

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            phase_q <= `QFP_PH_ONE;
        end else begin
            case (phase_q)
                `QFP_PH_ONE: phase_q <= `QFP_PH_TWO;
                `QFP_PH_TWO: phase_q <= `QFP_PH_THREE;
                `QFP_PH_THREE: phase_q <= `QFP_PH_FOUR;
                `QFP_PH_FOUR: phase_q <= `QFP_PH_ONE;
                // Illegal code recovers to phase one
                default: phase_q <= `QFP_PH_ONE;
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== qfp_osc_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----
// Oscillator source
// ----
module qfp_osc_src #(parameter realtime HALF = 2.0) (
    output var logic clock
);
    initial clock = 1'b0;
    // Free running: the core divides it itself
    always #(HALF) clock = ~clock;
endmodule
`default_nettype wire

// ==== qfp_fetch_pipe_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module qfp_fetch_pipe_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic master_clear_n,
    input wire logic [10:0] progAddr_q,
    input wire logic progRead_q,
    input wire logic [11:0] instrReg_q,
    input wire logic dataWrite_q,
    input wire logic phaseOne_q,
    input wire logic phaseTwo_q,
    input wire logic phaseThree_q,
    input wire logic phaseFour_q,
    input wire logic instr_rate_clock_out_q,
    input wire logic instr_rate_clock_oe_q
);
    // ----
    // Checks
    // ----
    default clocking @(posedge clock); endclocking
    // Pin low aborts: the synchroniser lag makes its edge fuzzy
    default disable iff (!rst_b || !master_clear_n);
    a_phase_onehot: assert property (
        $onehot0({phaseOne_q, phaseTwo_q, phaseThree_q, phaseFour_q})) else $error("phase overlap");
    a_phase_order: assert property (
        phaseOne_q |=> phaseTwo_q ##1 phaseThree_q ##1 phaseFour_q) else $error("phase order");
    a_cycle_period: assert property (phaseOne_q |-> ##4 phaseOne_q) else $error("period");
    a_pc_stable: assert property (phaseTwo_q |=> $stable(progAddr_q)) else $error("pc moved");
    a_fetch_once: assert property (progRead_q |=> !progRead_q [*3]) else $error("fetch");
    a_ir_stands: assert property (
        $changed(instrReg_q) |=> $stable(instrReg_q) [*3]) else $error("ir moved");
    a_write_once: assert property (dataWrite_q |=> !dataWrite_q [*3]) else $error("write");
    a_clk_duty: assert property (phaseOne_q && instr_rate_clock_oe_q |->
        !instr_rate_clock_out_q ##1 !instr_rate_clock_out_q ##1 instr_rate_clock_out_q
        ##1 instr_rate_clock_out_q) else $error("clock out");
endmodule
bind qfp_fetch_pipe qfp_fetch_pipe_chk u_chk (.*);
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // ----
    // Bench
    // ----
    wire clock;
    logic rst_b, master_clear_n, execBranch, execWriteEn;
    logic [1:0] osc_mode_select;
    logic [11:0] progData, fetched;
    logic [10:0] branchTarget, pcAt4;
    logic [6:0] execDataAddr;
    logic [7:0] execResult;
    logic [31:0] nd;
    wire [10:0] progAddr_q;
    wire [11:0] instrReg_q;
    wire [6:0] dataAddr_q;
    wire [7:0] dataWdata_q;
    wire progRead_q, instrValid_q, dataRead_q, dataWrite_q, phaseOne_q, phaseTwo_q;
    wire phaseThree_q, phaseFour_q, instr_rate_clock_out_q, instr_rate_clock_oe_q;
    int num_errors = 0, check_count = 0, hiCnt, oneCnt, rdCnt;
    bit run = 0, seen, got3, expFlush;
    qfp_osc_src osc (.clock(clock));
    qfp_fetch_pipe dut (.*);
    function automatic logic [11:0] memWord(input logic [10:0] a);
        return {1'b0, a} ^ 12'ha5c;
    endfunction
    function automatic logic [7:0] resOf(input logic [6:0] a);
        return {1'b0, a} ^ 8'h3c;
    endfunction
    task automatic chk(input string n, input logic [31:0] seenV, expV);
        check_count++;
        if (seenV !== expV) begin
            num_errors++;
            $display("[ERR] %s exp %0h seen %0h", n, expV, seenV);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clock) begin
        hiCnt += (instr_rate_clock_out_q === 1'b1);
        oneCnt += (phaseOne_q === 1'b1);
        rdCnt += (progRead_q === 1'b1);
    end
    always @(negedge clock) begin
        progData <= memWord(progAddr_q);
        if (run) begin
            if (dataWrite_q) chk("wdata", dataWdata_q, resOf(dataAddr_q));
            if (dataRead_q) chk("dread_ph", phaseTwo_q, 1'b1);
            if (phaseTwo_q && seen) chk("pc", progAddr_q, 11'(pcAt4 + 11'h1));
            if (phaseThree_q) begin
                if (seen) chk("valid", instrValid_q, !expFlush);
                if (seen && instrValid_q) chk("ir", instrReg_q, fetched);
                fetched = memWord(progAddr_q);
                expFlush = execBranch && instrValid_q;
                got3 = 1;
            end
            if (phaseFour_q) begin
                if (seen && expFlush) chk("target", progAddr_q, branchTarget);
                pcAt4 = progAddr_q;
                seen = got3;
                nd = $urandom;
                execBranch <= nd[31:30] == 2'h0;
                // Top address forces the counter to wrap
                branchTarget <= nd[29] ? 11'h7ff : nd[18:8];
                execDataAddr <= nd[6:0];
                execResult <= resOf(nd[6:0]);
                execWriteEn <= nd[20];
            end
        end
    end
    initial begin
        {rst_b, execBranch, execWriteEn, branchTarget, execDataAddr, execResult} = '0;
        {master_clear_n, osc_mode_select} = '0;
        nd = $urandom(38);
        repeat (16) @(negedge clock);
        rst_b = 1'b1;
        for (int m = 0; m < 4; m++) begin
            osc_mode_select = m[1:0];
            repeat (8) @(negedge clock);
            chk("pc_held", progAddr_q, 0);
            chk("valid_held", instrValid_q, 0);
            master_clear_n = 1'b1;
            repeat (8) @(negedge clock);
            #1 {hiCnt, oneCnt, rdCnt, seen, got3} = '0;
            run = 1;
            repeat (60) @(negedge clock);
            master_clear_n = 1'b0;
            #1 run = 0;
            chk("oe", instr_rate_clock_oe_q, m == 3);
            if (m == 3) chk("clk_high", hiCnt, 30);
            chk("phase_one", oneCnt, 15);
            chk("fetches", rdCnt, 15);
        end
        wrap_up();
    end
    initial begin
        #5000;
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
